// File: logic/rfcs_clk_div.sv
// Divider giving one-cycle enable pulses of the system clock
`timescale 1ns/10ps
`default_nettype none
`include "rfcs_params.svh"
module rfcs_clk_div (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [1:0] div_sel,
  output logic tick
);
  logic [2:0] cnt_r;
  logic [2:0] limit;
  always_comb begin
    unique case (div_sel)
      `RFCS_DIV_BY8: limit = 3'h7;
      `RFCS_DIV_BY4: limit = 3'h3;
      `RFCS_DIV_BY2: limit = 3'h1;
      `RFCS_DIV_BY1: limit = 3'h0;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (reset || !run) begin
      cnt_r <= 3'h0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_r >= limit);
      cnt_r <= (cnt_r >= limit) ? 3'h0 : cnt_r + 3'h1;
    end
  end
endmodule
`default_nettype wire

// File: logic/rfcs_params.svh
// Constants for the reset flag and clock select block
`ifndef RFCS_PARAMS_SVH
`define RFCS_PARAMS_SVH
`define RFCS_ADDR_RSTSRC 4'h0
`define RFCS_ADDR_OSCCTL 4'h1
`define RFCS_ADDR_OSCCAL 4'h2
`define RFCS_ADDR_CLKSEL 4'h3
`define RFCS_ADDR_STATUS 4'h4
`define RFCS_BIT_PIN_FLAG 0
`define RFCS_BIT_POR_FLAG 1
`define RFCS_BIT_MCDRSF 2
`define RFCS_BIT_OSCEN 7
`define RFCS_BIT_OSCRDY 6
`define RFCS_OSCCTL_RST 8'hc0
`define RFCS_DIV_BY8 2'h0
`define RFCS_DIV_BY4 2'h1
`define RFCS_DIV_BY2 2'h2
`define RFCS_DIV_BY1 2'h3
`define RFCS_CLK_MHZ 100
`define RFCS_MCD_TIMEOUT_US 220
`define RFCS_POR_DELAY_MS 100
`define RFCS_MCD_CYCLES (`RFCS_MCD_TIMEOUT_US * `RFCS_CLK_MHZ)
`define RFCS_POR_CYCLES (`RFCS_POR_DELAY_MS * 1000 * `RFCS_CLK_MHZ)
`endif

// File: logic/rfcs_pkg.sv
// Types for the reset flag and clock select block
package rfcs_pkg;
  typedef enum logic [1:0] {
    RFCS_SRC_INT,
    RFCS_SRC_INT_DIV,
    RFCS_SRC_EXT
  } rfcs_src_t;
  typedef enum logic [1:0] {
    RFCS_RST_HOLD,
    RFCS_RST_RUN,
    RFCS_RST_FORCE
  } rfcs_rst_state_t;
endpackage

// File: logic/rfcs_top.sv
// Reset source flags, missing clock detector, power-on delay and clock selection
`timescale 1ns/10ps
`default_nettype none
`include "rfcs_params.svh"
//
// Contract
// - The power-on flag reads 1 only after a power-on, supply monitor or software forced reset.
// - A missing system clock for the timeout starts a system reset.
// - After power comes up reset is held for the power-on delay before the pin is released.
// - The system clock can come from the external oscillator, the internal oscillator or a scaled internal clock.
// - Software enables, disables and calibrates the internal oscillator by its registers.
// - After any system reset the internal oscillator is the system clock.
// - The calibration value sets the internal oscillator period.
// - After reset the calibration holds the factory value for the base frequency.
// - The system clock can be the internal oscillator divided by 1, 2, 4 or 8 via the divide field.
module rfcs_top import rfcs_pkg::*; #(
  parameter int POR_CYCLES = `RFCS_POR_CYCLES,
  parameter int MCD_CYCLES = `RFCS_MCD_CYCLES,
  parameter logic [7:0] FACTORY_CAL = 8'h80
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic power_good,
  input wire logic monitor_trip,
  input wire logic pin_reset_in,
  input wire logic sysclk_alive,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  output logic sys_reset,
  output logic int_osc_en,
  output logic [7:0] int_osc_cal,
  output logic [1:0] clk_src,
  output logic sysclk_tick
);
  rfcs_rst_state_t st_r;
  logic [31:0] por_cnt_r;
  logic [31:0] mcd_cnt_r;
  logic power_on_reset_flag;
  logic pin_reset_flag;
  logic mcd_flag_r;
  logic mcd_en_r;
  logic [7:0] int_osc_control_reg;
  logic [7:0] int_osc_calibration_reg;
  logic [1:0] src_r;
  logic tick_w;
  wire wr_rst = wr_en && addr == `RFCS_ADDR_RSTSRC;
  wire wr_ctl = wr_en && addr == `RFCS_ADDR_OSCCTL;
  wire wr_cal = wr_en && addr == `RFCS_ADDR_OSCCAL;
  wire wr_sel = wr_en && addr == `RFCS_ADDR_CLKSEL;
  wire force_por = wr_rst && wdata[`RFCS_BIT_PIN_FLAG];
  wire mcd_fire = mcd_en_r && st_r == RFCS_RST_RUN && mcd_cnt_r >= MCD_CYCLES - 1;
  wire por_done = por_cnt_r >= POR_CYCLES - 1;
  wire [1:0] div_sel = int_osc_control_reg[1:0];
  wire osc_rdy = int_osc_control_reg[`RFCS_BIT_OSCEN];
  wire [7:0] rst_src_view = {5'h0, mcd_flag_r, power_on_reset_flag, pin_reset_flag};
  wire [7:0] ctl_view = {int_osc_control_reg[7], osc_rdy, 4'h0, int_osc_control_reg[1:0]};
  wire [7:0] rd_mux = addr == `RFCS_ADDR_RSTSRC ? rst_src_view :
                      addr == `RFCS_ADDR_OSCCTL ? ctl_view :
                      addr == `RFCS_ADDR_OSCCAL ? int_osc_calibration_reg :
                      addr == `RFCS_ADDR_CLKSEL ? {6'h0, src_r} :
                      addr == `RFCS_ADDR_STATUS ? {6'h0, st_r} : 8'h00;
  // Reset sequencer; a brown-out or software power-on restarts the full delay
  always_ff @(posedge core_clk) begin
    if (reset || !power_good || monitor_trip) begin
      st_r <= RFCS_RST_HOLD;
      por_cnt_r <= 32'h0;
    end else begin
      unique case (st_r)
        RFCS_RST_HOLD: begin
          por_cnt_r <= por_cnt_r + 32'h1;
          if (por_done) st_r <= RFCS_RST_RUN;
        end
        RFCS_RST_RUN: begin
          if (force_por || mcd_fire) st_r <= RFCS_RST_FORCE;
          else if (pin_reset_in) st_r <= RFCS_RST_FORCE;
        end
        RFCS_RST_FORCE: begin
          por_cnt_r <= 32'h0;
          st_r <= RFCS_RST_HOLD;
        end
      endcase
    end
  end
  // Flags describe only the latest cause, so each reset entry rewrites all of them
  always_ff @(posedge core_clk) begin
    if (reset || !power_good || monitor_trip) begin
      power_on_reset_flag <= 1'b1;
      pin_reset_flag <= 1'b0;
      mcd_flag_r <= 1'b0;
    end else if (st_r == RFCS_RST_RUN && (force_por || mcd_fire || pin_reset_in)) begin
      power_on_reset_flag <= force_por;
      pin_reset_flag <= !force_por && !mcd_fire;
      mcd_flag_r <= !force_por && mcd_fire;
    end
  end
  // Missing clock counter runs on core_clk while the system clock is idle
  always_ff @(posedge core_clk) begin
    if (reset || st_r != RFCS_RST_RUN || sysclk_alive) mcd_cnt_r <= 32'h0;
    else mcd_cnt_r <= mcd_cnt_r + 32'h1;
  end
  // Oscillator registers return to defaults on every system reset
  always_ff @(posedge core_clk) begin
    if (reset || st_r != RFCS_RST_RUN) begin
      int_osc_control_reg <= `RFCS_OSCCTL_RST;
      int_osc_calibration_reg <= FACTORY_CAL;
      src_r <= RFCS_SRC_INT;
      mcd_en_r <= 1'b0;
    end else begin
      if (wr_ctl) int_osc_control_reg <= {wdata[7], 5'h0, wdata[1:0]};
      if (wr_cal) int_osc_calibration_reg <= wdata;
      if (wr_sel && wdata[1:0] != 2'h3) src_r <= wdata[1:0];
      if (wr_rst) mcd_en_r <= wdata[`RFCS_BIT_MCDRSF];
    end
  end
  rfcs_clk_div u_div (
    .core_clk(core_clk),
    .reset(reset),
    .run(int_osc_control_reg[`RFCS_BIT_OSCEN]),
    .div_sel(div_sel),
    .tick(tick_w)
  );
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata <= 8'h00;
      rst_pin_out <= 1'b0;
      rst_pin_oe <= 1'b1;
      sys_reset <= 1'b1;
      int_osc_en <= 1'b1;
      int_osc_cal <= FACTORY_CAL;
      clk_src <= RFCS_SRC_INT;
      sysclk_tick <= 1'b0;
    end else begin
      rdata <= rd_en ? rd_mux : 8'h00;
      rst_pin_out <= 1'b0;
      rst_pin_oe <= st_r != RFCS_RST_RUN || force_por;
      sys_reset <= st_r != RFCS_RST_RUN;
      int_osc_en <= int_osc_control_reg[`RFCS_BIT_OSCEN];
      int_osc_cal <= int_osc_calibration_reg;
      clk_src <= src_r;
      sysclk_tick <= src_r == RFCS_SRC_INT ? int_osc_control_reg[`RFCS_BIT_OSCEN] : tick_w;
    end
  end
  chk_por_hold_pin: assert property (@(posedge core_clk) disable iff (reset)
    $rose(st_r == RFCS_RST_HOLD) |-> ##1 rst_pin_oe) else $error("pin released during hold");
  chk_force_por: assert property (@(posedge core_clk) disable iff (reset)
    (st_r == RFCS_RST_RUN && force_por && power_good && !monitor_trip) |-> ##1 rst_pin_oe ##1 sys_reset)
    else $error("forced reset missing");
  chk_flag_por: assert property (@(posedge core_clk) disable iff (reset)
    (st_r == RFCS_RST_RUN && pin_reset_in && !force_por && !mcd_fire && power_good && !monitor_trip)
    |=> !power_on_reset_flag && pin_reset_flag) else $error("flags wrong after pin reset");
  chk_mcd_reset: assert property (@(posedge core_clk) disable iff (reset)
    (mcd_fire && power_good && !monitor_trip) |=> st_r == RFCS_RST_FORCE) else $error("clock loss ignored");
  chk_sel_default: assert property (@(posedge core_clk) disable iff (reset)
    (st_r == RFCS_RST_FORCE) |-> ##2 clk_src == RFCS_SRC_INT) else $error("source not internal");
  chk_cal_default: assert property (@(posedge core_clk) disable iff (reset)
    (st_r == RFCS_RST_FORCE) |-> ##2 int_osc_cal == FACTORY_CAL) else $error("calibration not restored");
  chk_cal_write: assert property (@(posedge core_clk) disable iff (reset)
    (wr_cal && st_r == RFCS_RST_RUN && power_good && !monitor_trip) |-> ##2 int_osc_cal == $past(wdata, 2))
    else $error("calibration not applied");
  chk_osc_enable: assert property (@(posedge core_clk) disable iff (reset)
    (wr_ctl && st_r == RFCS_RST_RUN && power_good && !monitor_trip) |-> ##2 int_osc_en == $past(wdata[7], 2))
    else $error("enable not applied");
endmodule
`default_nettype wire

// File: verification/reset_flags_and_clock_select_tb.sv
// Self-checking bench for the reset flag and clock select block
`timescale 1ns/10ps
`default_nettype none
`include "rfcs_params.svh"
module reset_flags_and_clock_select_tb;
  import rfcs_pkg::*;
  logic core_clk, reset, power_good, monitor_trip, pin_reset_in, sysclk_alive, wr_en, rd_en;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, int_osc_cal, rd_v;
  logic rst_pin_out, rst_pin_oe, sys_reset, int_osc_en, sysclk_tick;
  logic [1:0] clk_src;
  int miscompares, num_checks, n, exp_cal;
  // Short counts keep the run small; expectations follow these values
  rfcs_top #(.POR_CYCLES(50), .MCD_CYCLES(20)) dut (.core_clk(core_clk), .reset(reset),
    .power_good(power_good), .monitor_trip(monitor_trip), .pin_reset_in(pin_reset_in),
    .sysclk_alive(sysclk_alive), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .sys_reset(sys_reset),
    .int_osc_en(int_osc_en), .int_osc_cal(int_osc_cal), .clk_src(clk_src), .sysclk_tick(sysclk_tick));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a; wdata <= d; wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    addr <= a; rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 rd_v = rdata;
  endtask
  // Bounded wait for sys_reset to reach a level
  task automatic wait_rst(input logic lvl, input int lim);
    n = 0;
    while (sys_reset !== lvl && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    chk("sys_reset", {7'h0, sys_reset}, {7'h0, lvl});
  endtask
  initial begin
    #300us;
    miscompares++;
    close_out();
  end
  initial begin
    reset = 1'b1; power_good = 1'b1; monitor_trip = 1'b0; pin_reset_in = 1'b0; sysclk_alive = 1'b1;
    wr_en = 1'b0; rd_en = 1'b0; addr = 4'h0; wdata = 8'h00;
    miscompares = 0; num_checks = 0;
    void'($urandom(32'had9c));
    repeat (10) @(posedge core_clk);
    #1;
    chk("cal", int_osc_cal, 8'h80);
    chk("src", {6'h0, clk_src}, {6'h0, RFCS_SRC_INT});
    chk("pin_oe", {7'h0, rst_pin_oe}, 8'h01);
    reset <= 1'b0;
    repeat (45) @(posedge core_clk);
    chk("early", {7'h0, sys_reset}, 8'h01);
    wait_rst(1'b0, 20);
    rd(4'h9);
    chk("unmapped", rd_v, 8'h00);
    rd(`RFCS_ADDR_OSCCTL);
    chk("ctl", rd_v, `RFCS_OSCCTL_RST);
    chk("tick_int", {7'h0, sysclk_tick}, 8'h01);
    // Each divide code: sysclk_tick count over 16 cycles is 16 over the ratio
    wr(`RFCS_ADDR_CLKSEL, 8'h01);
    for (int d = 0; d < 4; d++) begin
      wr(`RFCS_ADDR_OSCCTL, {6'h20, d[1:0]});
      n = 0;
      repeat (16) begin
        @(posedge core_clk);
        n += sysclk_tick;
      end
      chk("ticks", n[7:0], 8'(2 << d));
    end
    // Staying at or below the factory value keeps the oscillator under its top frequency
    exp_cal = $urandom_range(0, 128);
    wr(`RFCS_ADDR_OSCCAL, exp_cal[7:0]);
    chk("cal_out", int_osc_cal, exp_cal[7:0]);
    rd(`RFCS_ADDR_OSCCAL);
    chk("cal_rd", rd_v, exp_cal[7:0]);
    wr(`RFCS_ADDR_OSCCTL, 8'h03);
    chk("osc_en", {7'h0, int_osc_en}, 8'h00);
    wr(`RFCS_ADDR_CLKSEL, 8'h02);
    wr(`RFCS_ADDR_CLKSEL, 8'h03);
    chk("src_ext", {6'h0, clk_src}, {6'h0, RFCS_SRC_EXT});
    // Software forced reset drives the pin and restores defaults
    wr(`RFCS_ADDR_RSTSRC, 8'h01);
    chk("force_oe", {7'h0, rst_pin_oe}, 8'h01);
    chk("force_lvl", {7'h0, rst_pin_out}, 8'h00);
    wait_rst(1'b0, 80);
    chk("src_def", {6'h0, clk_src}, {6'h0, RFCS_SRC_INT});
    chk("cal_def", int_osc_cal, 8'h80);
    rd(`RFCS_ADDR_RSTSRC);
    chk("flags_force", {6'h0, rd_v[1:0]}, 8'h02);
    // Supply monitor trip, then pin reset
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      if (i == 0) monitor_trip <= 1'b1;
      else pin_reset_in <= 1'b1;
      repeat (3) @(posedge core_clk);
      monitor_trip <= 1'b0;
      pin_reset_in <= 1'b0;
      wait_rst(1'b0, 80);
      rd(`RFCS_ADDR_RSTSRC);
      chk("flags_src", {6'h0, rd_v[1:0]}, (i == 0) ? 8'h02 : 8'h01);
    end
    // Missing clock detector trips after its timeout
    wr(`RFCS_ADDR_RSTSRC, 8'h04);
    sysclk_alive <= 1'b0;
    repeat (15) @(posedge core_clk);
    chk("mcd_early", {7'h0, sys_reset}, 8'h00);
    wait_rst(1'b1, 15);
    sysclk_alive <= 1'b1;
    wait_rst(1'b0, 80);
    rd(`RFCS_ADDR_RSTSRC);
    chk("flags_mcd", {5'h0, rd_v[2:0]}, 8'h04);
    close_out();
  end
endmodule
`default_nettype wire
